/* File: include/vifd_pkg.sv */
package vifd_pkg;
   localparam int ADDR_W = 32;
   localparam int LEN_W = 16;
   localparam int PAGE_SHIFT = 6;
   localparam int PAGE_W = LEN_W - PAGE_SHIFT;
   localparam logic [LEN_W:0] PAGE_SWORDS = 17'h00040;
   // byte designator positions, counted from the left
   localparam int POS_F = 0;
   localparam int POS_G = 8;
   localparam int POS_X = 16;
   localparam int POS_A = 24;
   localparam int POS_Y = 32;
   localparam int POS_B = 40;
   localparam int POS_Z = 48;
   localparam int POS_C = 56;
   localparam logic [7:0] FC_LONG_MIN = 8'h80;
   localparam logic [7:0] FC_LD12 = 8'h12;
   localparam logic [7:0] FC_ST13 = 8'h13;
   localparam logic [7:0] FC_BR32 = 8'h32;
   localparam logic [7:0] FC_BR33 = 8'h33;
   localparam logic [7:0] FC_LD5E = 8'h5E;
   localparam logic [7:0] FC_ST5F = 8'h5F;
   localparam logic [7:0] FC_LD7E = 8'h7E;
   localparam logic [7:0] FC_ST7F = 8'h7F;
   localparam logic [7:0] FC_XMIT78 = 8'h78;
   localparam logic [7:0] FC_SPV_LO = 8'hA0;
   localparam logic [7:0] FC_SPV_HI = 8'hAF;
   localparam logic [7:0] FC_CMPR_BC = 8'hBC;
   localparam logic [7:0] FC_CMPR_CF = 8'hCF;
   localparam logic [7:0] FC_TR_D7 = 8'hD7;
   localparam logic [7:0] FC_TR_EE = 8'hEE;
   localparam logic [7:0] FC_TR_F8 = 8'hF8;
   localparam logic [7:0] FC_TR_F9 = 8'hF9;
   localparam logic [7:0] MON_BRANCH_REG = 8'h04;
   localparam logic [1:0] HALVES_SHORT = 2'h1;
   localparam logic [1:0] HALVES_LONG = 2'h2;
   localparam logic [5:0] ALIGN_BYTE = 6'h07;
   localparam logic [5:0] ALIGN_HALF = 6'h1F;
   localparam logic [5:0] ALIGN_WORD = 6'h3F;
   localparam logic [ADDR_W:0] SMC_BEFORE = 33'h000000018;
   localparam logic [ADDR_W:0] SMC_AFTER = 33'h000000020;
   localparam logic [ADDR_W:0] SYNC_BEFORE = 33'h000000003;
   localparam logic [ADDR_W:0] SYNC_AFTER = 33'h000000004;
   typedef enum logic [3:0] {
      FMT_NONE = 4'h0, FMT_VEC = 4'h1, FMT_SPARSE = 4'h2, FMT_STRING = 4'h3,
      FMT_REG = 4'h4, FMT_BR32 = 4'h9, FMT_BR33 = 4'hB
   } vifd_fmt_e;
   typedef enum logic [1:0] {OS_BIT = 2'h0, OS_BYTE = 2'h1, OS_HALF = 2'h2, OS_WORD = 2'h3} vifd_osize_e;
   typedef enum logic [1:0] {SO_CLEAR = 2'h0, SO_PEND = 2'h1, SO_DRAIN = 2'h3} vifd_so_e;
   typedef struct packed {
      logic len64;
      logic [1:0] halves;
      vifd_fmt_e fmt;
      logic [7:0] func;
      logic [0:7] sub;
      logic [7:0] x, a, y, b, z, c, c_next;
      logic [7:0] src1, src2, dst;
   } vifd_fields_s;
   typedef struct packed {
      logic illegal, exch_monitor, mon_branch;
      logic [7:0] mon_reg;
      logic pair_odd, misaligned, smc_unhonoured;
   } vifd_exc_s;
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      vifd_osize_e size;
      logic packed_bcd;
      logic [LEN_W-1:0] bytes;
   } vifd_opnd_s;
   typedef struct packed {
      logic [LEN_W-1:0] pos, z_len, delim_pos;
      logic delim_seen, done;
   } vifd_res_s;
endpackage : vifd_pkg

/* File: logic/vifd_decoder.sv */
`timescale 1ns/1ps
module vifd_decoder #(
   // which function codes are assigned; the default marks all as assigned
   parameter logic [255:0] LEGAL_MAP = {256{1'b1}},
   // long codes from here up use the string layout, below it the vector one except A0-AF, which use the sparse one
   parameter logic [7:0] STR_LO = 8'hC0
) (
   input logic ref_clk,
   input logic rst,
   input logic in_valid,
   input logic [0:63] in_word,
   input logic job_mode,
   input logic mem_ref,
   input logic br32_taken,
   input logic [vifd_pkg::ADDR_W-1:0] cur_addr,
   input logic mod_valid,
   input logic [vifd_pkg::ADDR_W-1:0] mod_addr,
   input logic store_done,
   input vifd_pkg::vifd_opnd_s opnd,
   input vifd_pkg::vifd_res_s res,
   output logic out_valid,
   output vifd_pkg::vifd_fields_s out_fields,
   output vifd_pkg::vifd_exc_s out_exc,
   output logic fetch_hold,
   output logic order_ok,
   output logic [vifd_pkg::LEN_W:0] digit_count,
   output logic probe,
   output logic [vifd_pkg::PAGE_W:0] probe_page,
   output logic [vifd_pkg::LEN_W-1:0] result_len
);
   import vifd_pkg::*;

   typedef struct packed {
      logic valid;
      vifd_fields_s f;
      vifd_exc_s e;
      logic hold;
      logic ok;
      logic [LEN_W:0] digits;
      logic probe;
      logic [PAGE_W:0] page;
      logic [LEN_W-1:0] rlen;
   } vifd_top_s;

   vifd_top_s s_reg, s_next;
   logic fence_next;
   logic sync_seen;
   logic [ADDR_W-1:0] sync_addr;
   logic la_probe;
   logic [PAGE_W:0] la_page;
   logic [LEN_W-1:0] la_rlen;
   logic [7:0] in_func;
   logic [ADDR_W:0] cur_x;
   logic [ADDR_W:0] mod_x;
   logic [ADDR_W:0] sync_x;

   // format number from the function code
   function automatic vifd_fmt_e fmt_of(input logic [7:0] fc);
      vifd_fmt_e r;
      r = FMT_REG;
      if (fc >= FC_LONG_MIN) begin
         if (fc >= FC_SPV_LO && fc <= FC_SPV_HI) begin
            r = FMT_SPARSE;
         end else if (fc >= STR_LO) begin
            r = FMT_STRING;
         end else begin
            r = FMT_VEC;
         end
      end else if (fc == FC_BR32) begin
         r = FMT_BR32;
      end else if (fc == FC_BR33) begin
         r = FMT_BR33;
      end
      return r;
   endfunction : fmt_of

   // byte designators; unused fields are left at zero
   function automatic vifd_fields_s fields_of(input logic [0:63] w);
      vifd_fields_s f;
      f = '0;
      f.func = w[POS_F +: 8];
      f.len64 = f.func >= FC_LONG_MIN;
      f.halves = f.len64 ? HALVES_LONG : HALVES_SHORT;
      f.fmt = fmt_of(f.func);
      f.sub = w[POS_G +: 8];
      f.x = w[POS_X +: 8];
      f.a = w[POS_A +: 8];
      // short words carry nothing past bit 31
      if (f.len64) begin
         f.y = w[POS_Y +: 8];
         f.b = w[POS_B +: 8];
         f.z = w[POS_Z +: 8];
         f.c = w[POS_C +: 8];
         f.c_next = f.c + 8'h01;
      end else begin
         f.src1 = w[POS_G +: 8];
         f.src2 = w[POS_X +: 8];
         f.dst = w[POS_A +: 8];
      end
      return f;
   endfunction : fields_of

   // leftmost bit address must be a multiple of the operand size
   function automatic logic misaligned_of(input vifd_opnd_s o);
      logic m;
      m = 1'b0;
      unique case (o.size)
         OS_BIT: m = 1'b0;
         OS_BYTE: m = |(o.addr[5:0] & ALIGN_BYTE);
         OS_HALF: m = |(o.addr[5:0] & ALIGN_HALF);
         OS_WORD: m = |(o.addr[5:0] & ALIGN_WORD);
      endcase
      return m;
   endfunction : misaligned_of

   assign in_func = in_word[POS_F +: 8];
   assign cur_x = {1'b0, cur_addr};
   assign mod_x = {1'b0, mod_addr};
   assign sync_x = {1'b0, sync_addr};

   // deferred store tracking and fetch fence
   vifd_store_order u_store (
      .ref_clk(ref_clk),
      .rst(rst),
      .issue(in_valid),
      .func(in_func),
      .src_reg(in_word[POS_G +: 8]),
      .dst_reg(in_word[POS_A +: 8]),
      .mem_ref(mem_ref),
      .br_taken(br32_taken),
      .cur_addr(cur_addr),
      .store_done(store_done),
      .fence_next(fence_next),
      .sync_seen(sync_seen),
      .sync_addr(sync_addr)
   );

   // result page lookahead for data-dependent lengths
   vifd_lookahead u_look (
      .ref_clk(ref_clk),
      .rst(rst),
      .issue(in_valid),
      .func(in_func),
      .res(res),
      .probe(la_probe),
      .probe_page(la_page),
      .result_len(la_rlen)
   );

   // decode presented word; fields and exceptions land on the next edge, probe and sync results one edge later
   always_comb begin
      s_next = s_reg;
      s_next.valid = in_valid;
      if (in_valid) begin
         s_next.f = fields_of(in_word);
         s_next.e = '0;
         s_next.e.illegal = !LEGAL_MAP[in_func];
         s_next.e.exch_monitor = !LEGAL_MAP[in_func] && job_mode;
         s_next.e.mon_branch = !LEGAL_MAP[in_func] && !job_mode;
         s_next.e.mon_reg = MON_BRANCH_REG;
         // an odd result register makes the offset pair meaningless
         s_next.e.pair_odd = fmt_of(in_func) == FMT_VEC && in_word[POS_C + 7];
         s_next.e.misaligned = misaligned_of(opnd);
         // a store this close may be missed by prefetched code
         s_next.e.smc_unhonoured = mod_valid
            && mod_x + SMC_BEFORE >= cur_x
            && mod_x <= cur_x + SMC_AFTER;
         // packed digits double the byte count
         s_next.digits = opnd.packed_bcd ? {opnd.bytes, 1'b0} : {1'b0, opnd.bytes};
      end
      // held fetch until the deferred stores are written
      s_next.hold = fence_next;
      // sync far enough from the modified code to count
      s_next.ok = sync_seen && mod_valid
         && (sync_x + SYNC_BEFORE <= mod_x || sync_x >= mod_x + SYNC_AFTER);
      s_next.probe = la_probe;
      s_next.page = la_page;
      s_next.rlen = la_rlen;
   end

   always_ff @(posedge ref_clk) begin
      if (rst) s_reg <= '0;
      else s_reg <= s_next;
   end

   // every output is a flip-flop of the state record
   assign out_valid = s_reg.valid;
   assign out_fields = s_reg.f;
   assign out_exc = s_reg.e;
   assign fetch_hold = s_reg.hold;
   assign order_ok = s_reg.ok;
   assign digit_count = s_reg.digits;
   assign probe = s_reg.probe;
   assign probe_page = s_reg.page;
   assign result_len = s_reg.rlen;
endmodule : vifd_decoder

/* File: logic/vifd_lookahead.sv */
`timescale 1ns/1ps
module vifd_lookahead (
   input logic ref_clk,
   input logic rst,
   input logic issue,
   input logic [7:0] func,
   input vifd_pkg::vifd_res_s res,
   output logic probe,
   output logic [vifd_pkg::PAGE_W:0] probe_page,
   output logic [vifd_pkg::LEN_W-1:0] result_len
);
   import vifd_pkg::*;
   typedef struct packed {
      logic active, sparse, delim;
      logic [PAGE_W-1:0] page;
      logic probe;
      logic [PAGE_W:0] ppage;
      logic [LEN_W-1:0] rlen;
   } vifd_la_s;
   vifd_la_s s_reg, s_next;
   logic spv, trans, cls;
   logic [PAGE_W-1:0] cur_page;
   logic [LEN_W:0] next_start;

   // one page ahead of the result pointer
   always_comb begin
      s_next = s_reg;
      s_next.probe = 1'b0;
      spv = func >= FC_SPV_LO && func <= FC_SPV_HI;
      trans = func == FC_TR_D7 || func == FC_TR_EE || func == FC_TR_F8 || func == FC_TR_F9;
      cls = spv || trans || func == FC_CMPR_BC || func == FC_CMPR_CF;
      cur_page = res.pos[LEN_W-1:PAGE_SHIFT];
      next_start = {1'b0, cur_page + 1'b1, {PAGE_SHIFT{1'b0}}};
      if (issue && cls) begin
         s_next.active = 1'b1;
         s_next.sparse = spv;
         s_next.delim = trans;
         s_next.page = '0;
         s_next.rlen = spv ? res.z_len : '0;
         s_next.probe = !spv || {1'b0, res.z_len} > PAGE_SWORDS;
         s_next.ppage = {{PAGE_W{1'b0}}, 1'b1};
      end else if (s_reg.active) begin
         if (res.done) begin
            s_next.active = 1'b0;
         end else if (cur_page != s_reg.page) begin
            s_next.page = cur_page;
            s_next.ppage = {1'b0, cur_page} + 1'b1;
            s_next.probe = !s_reg.sparse || next_start < {1'b0, s_reg.rlen};
         end
         if (s_reg.delim && res.delim_seen) s_next.rlen = res.delim_pos;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) s_reg <= '0;
      else s_reg <= s_next;
   end

   assign probe = s_reg.probe;
   assign probe_page = s_reg.ppage;
   assign result_len = s_reg.rlen;
endmodule : vifd_lookahead

/* File: logic/vifd_store_order.sv */
`timescale 1ns/1ps
module vifd_store_order (
   input logic ref_clk,
   input logic rst,
   input logic issue,
   input logic [7:0] func,
   input logic [7:0] src_reg,
   input logic [7:0] dst_reg,
   input logic mem_ref,
   input logic br_taken,
   input logic [vifd_pkg::ADDR_W-1:0] cur_addr,
   input logic store_done,
   output logic fence_next,
   output logic sync_seen,
   output logic [vifd_pkg::ADDR_W-1:0] sync_addr
);
   import vifd_pkg::*;
   typedef struct packed {
      vifd_so_e st;
      logic last_load;
      logic [7:0] load_dst;
      logic seen;
      logic [ADDR_W-1:0] addr;
   } vifd_so_s;
   vifd_so_s s_reg, s_next;
   logic defer, exempt, is_load, sync;

   // classify and track deferred stores
   always_comb begin
      s_next = s_reg;
      is_load = func == FC_LD12 || func == FC_LD5E || func == FC_LD7E;
      defer = issue && (func == FC_ST13 || func == FC_ST5F || func == FC_ST7F);
      exempt = is_load || defer || func == FC_ST13 || func == FC_BR32;
      sync = issue && ((mem_ref && !exempt)
         || (func == FC_BR32 && br_taken)
         || (func == FC_XMIT78 && s_reg.last_load && src_reg == s_reg.load_dst));
      if (issue) begin
         s_next.last_load = is_load;
         s_next.load_dst = dst_reg;
      end
      // a new deferred store forgets older syncs
      if (defer) begin
         s_next.seen = 1'b0;
      end
      if (sync) begin
         s_next.seen = 1'b1;
         s_next.addr = cur_addr;
      end
      unique case (s_reg.st)
         SO_CLEAR: begin
            if (defer) s_next.st = SO_PEND;
         end
         SO_PEND: begin
            if (sync) s_next.st = SO_DRAIN;
         end
         SO_DRAIN: begin
            if (store_done) s_next.st = defer ? SO_PEND : SO_CLEAR; // a fresh store is not lost
         end
         default: s_next.st = SO_CLEAR;
      endcase
      fence_next = s_next.st == SO_DRAIN;
   end

   always_ff @(posedge ref_clk) begin
      if (rst) s_reg <= '0;
      else s_reg <= s_next;
   end

   assign sync_seen = s_reg.seen;
   assign sync_addr = s_reg.addr;
endmodule : vifd_store_order

/* File: tb/tb.sv */
`timescale 1ns/1ps
module tb;
   import vifd_pkg::*;
   // code FE left unassigned to reach the trap path
   localparam logic [255:0] MAP = ~(256'h1 << 8'hFE);
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic in_valid = 1'b0;
   logic [0:63] in_word = '0;
   logic job_mode = 1'b1;
   logic mem_ref = 1'b0;
   logic br32_taken = 1'b0;
   logic [ADDR_W-1:0] cur_addr = 32'h00000100;
   logic mod_valid = 1'b0;
   logic [ADDR_W-1:0] mod_addr = '0;
   logic store_done;
   vifd_opnd_s opnd = '0;
   vifd_res_s res = '0;
   logic out_valid, fetch_hold, order_ok, probe;
   vifd_fields_s f;
   vifd_exc_s e;
   logic [LEN_W:0] digit_count;
   logic [PAGE_W:0] probe_page;
   logic [LEN_W-1:0] result_len;
   int miscompares = 0;
   int checks = 0;
   int cyc = 0;

   vifd_decoder #(.LEGAL_MAP(MAP)) dut (.ref_clk(ref_clk), .rst(rst), .in_valid(in_valid),
      .in_word(in_word), .job_mode(job_mode), .mem_ref(mem_ref), .br32_taken(br32_taken),
      .cur_addr(cur_addr), .mod_valid(mod_valid), .mod_addr(mod_addr), .store_done(store_done),
      .opnd(opnd), .res(res), .out_valid(out_valid), .out_fields(f), .out_exc(e),
      .fetch_hold(fetch_hold), .order_ok(order_ok), .digit_count(digit_count), .probe(probe),
      .probe_page(probe_page), .result_len(result_len));
   vifd_issue_model #(.DELAY(3)) u_mem (.ref_clk(ref_clk), .rst(rst), .fetch_hold(fetch_hold),
      .store_done(store_done));

   always #5 ref_clk = ~ref_clk;
   // hang guard, far above the hundred or so cycles the tests need
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 4000) begin
         miscompares++;
         final_report();
      end
   end

   task automatic chk(string n, logic [63:0] s, logic [63:0] x);
      checks++;
      if (s !== x) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", n, x, s);
      end
   endtask : chk

   // one word per instruction; outputs sampled once the answer edge settles
   task automatic present(logic [0:63] w, logic m, logic b);
      @(posedge ref_clk);
      in_valid <= 1'b1;
      in_word <= w;
      mem_ref <= m;
      br32_taken <= b;
      @(posedge ref_clk);
      in_valid <= 1'b0;
      mem_ref <= 1'b0;
      br32_taken <= 1'b0;
      #1;
   endtask : present

   // no new word while stalled, so wait for the stall to clear
   task automatic drain();
      for (int n = 0; n < 20 && fetch_hold !== 1'b0; n++) begin
         @(posedge ref_clk);
         #1;
      end
      chk("fetch_hold", fetch_hold, 0);
   endtask : drain

   task automatic t_formats();
      logic [7:0] codes [8] = '{8'h00, 8'h7F, 8'h32, 8'h33, 8'h80, 8'hBF, 8'hC0, 8'hFF};
      logic [3:0] fmts [8] = '{4'h4, 4'h4, 4'h9, 4'hB, 4'h1, 4'h1, 4'h3, 4'h3};
      for (int i = 0; i < 8; i++) begin
         present({codes[i], 56'h5A10213243546E}, 1'b0, 1'b0);
         chk("out_valid", out_valid, 1);
         chk("len64", f.len64, codes[i][7]);
         chk("fmt", f.fmt, fmts[i]);
         chk("func", f.func, codes[i]);
         chk("sub", f.sub, 8'h5A);
         chk("pair_odd", e.pair_odd, 0);
         if (codes[i][7]) chk("x to c", {f.x, f.a, f.y, f.b, f.z, f.c}, 48'h10213243546E);
         if (codes[i][7]) chk("c_next", f.c_next, 8'h6F);
         else chk("src dst", {f.src1, f.src2, f.dst}, 24'h5A1021);
      end
      present({8'h80, 48'h0, 8'h07}, 1'b0, 1'b0);
      chk("pair_odd", e.pair_odd, 1);
      $display("formats test done");
   endtask : t_formats

   task automatic t_trap();
      present({8'hFE, 56'h0}, 1'b0, 1'b0);
      chk("illegal", e.illegal, 1);
      chk("exch_monitor", e.exch_monitor, 1);
      job_mode <= 1'b0;
      present({8'hFE, 56'h0}, 1'b0, 1'b0);
      chk("mon_branch", {e.mon_branch, e.mon_reg}, 9'h104);
      job_mode <= 1'b1;
      present({8'h80, 56'h0}, 1'b0, 1'b0);
      chk("illegal", e.illegal, 0);
      $display("trap test done");
   endtask : t_trap

   task automatic t_align();
      vifd_osize_e sz [6] = '{OS_HALF, OS_HALF, OS_WORD, OS_WORD, OS_BYTE, OS_BIT};
      logic [31:0] ad [6] = '{32'h20, 32'h30, 32'h40, 32'h60, 32'h4, 32'h3};
      logic mis [6] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
      for (int i = 0; i < 6; i++) begin
         opnd <= '{ad[i], sz[i], i[0], 16'h0005};
         present({8'h10, 56'h0}, 1'b0, 1'b0);
         chk("misaligned", e.misaligned, mis[i]);
         chk("digit_count", digit_count, i[0] ? 17'h0000A : 17'h00005);
      end
      $display("align test done");
   endtask : t_align

   task automatic t_store();
      present({8'h13, 56'h0}, 1'b1, 1'b0);
      present({8'h12, 16'h0, 8'h05, 32'h0}, 1'b1, 1'b0);
      chk("fetch_hold", fetch_hold, 0);
      present({8'h78, 8'h05, 48'h0}, 1'b0, 1'b0);
      chk("fetch_hold", fetch_hold, 1);
      drain();
      present({8'h5F, 56'h0}, 1'b1, 1'b0);
      present({8'h32, 56'h0}, 1'b0, 1'b1);
      chk("fetch_hold", fetch_hold, 1);
      drain();
      present({8'h7F, 56'h0}, 1'b1, 1'b0);
      present({8'h10, 56'h0}, 1'b1, 1'b0);
      chk("fetch_hold", fetch_hold, 1);
      drain();
      $display("store order test done");
   endtask : t_store

   // sync distance to the modified code, then the nearby-store warning
   task automatic t_order();
      logic [31:0] ma [5] = '{32'h00000103, 32'h00000102, 32'h000000FC, 32'h000000E8, 32'h00000121};
      logic want [5] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
      for (int i = 0; i < 5; i++) begin
         @(posedge ref_clk);
         mod_valid <= 1'b1;
         mod_addr <= ma[i];
         if (i < 3) begin
            @(posedge ref_clk);
            #1;
            chk("order_ok", order_ok, want[i]);
         end else begin
            present({8'h10, 56'h0}, 1'b0, 1'b0);
            chk("smc_unhonoured", e.smc_unhonoured, want[i]);
         end
      end
      // a fresh deferred store voids the earlier sync
      present({8'h13, 56'h0}, 1'b1, 1'b0);
      @(posedge ref_clk);
      #1;
      chk("order_ok", order_ok, 0);
      mod_valid <= 1'b0;
      $display("store distance test done");
   endtask : t_order

   task automatic t_lookahead();
      present({8'hBC, 56'h0}, 1'b0, 1'b0);
      @(posedge ref_clk);
      #1;
      chk("probe", {probe, probe_page}, 12'h801);
      res.z_len <= 16'h0010;
      present({8'hA0, 56'h0}, 1'b0, 1'b0);
      @(posedge ref_clk);
      #1;
      chk("probe", probe, 0);
      chk("result_len", result_len, 16'h0010);
      // delimiter-limited translate: length follows the delimiter
      res.delim_pos <= 16'h0025;
      res.delim_seen <= 1'b1;
      present({8'hD7, 56'h0}, 1'b0, 1'b0);
      @(posedge ref_clk);
      #1;
      chk("probe", {probe, probe_page}, 12'h801);
      @(posedge ref_clk);
      #1;
      chk("result_len", result_len, 16'h0025);
      // crossing into the next small page probes the one after it
      res.pos <= 16'h0040;
      repeat (2) @(posedge ref_clk);
      #1;
      chk("probe", {probe, probe_page}, 12'h802);
      $display("lookahead test done");
   endtask : t_lookahead

   task automatic final_report();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : final_report

   initial begin
      repeat (5) @(posedge ref_clk);
      rst <= 1'b0;
      #1;
      chk("idle", {out_valid, fetch_hold, probe}, 0);
      t_formats();
      t_trap();
      t_align();
      t_store();
      t_order();
      t_lookahead();
      final_report();
   end
endmodule : tb

/* File: tb/vifd_issue_model.sv */
`timescale 1ns/1ps
// memory side: finishes deferred stores some cycles after the stall starts
module vifd_issue_model #(
   parameter int DELAY = 3
) (
   input logic ref_clk,
   input logic rst,
   input logic fetch_hold,
   output logic store_done
);
   int cnt;
   // one pulse per stall; a slow answer keeps the stall visible for a while
   always @(posedge ref_clk) begin
      store_done <= 1'b0;
      if (rst || !fetch_hold) begin
         cnt <= 0;
      end else begin
         cnt <= cnt + 1;
         if (cnt == DELAY) store_done <= 1'b1;
      end
   end
endmodule : vifd_issue_model

/* File: tb/vifd_properties.sv */
`timescale 1ns/1ps
// watches the decoder ports; answers are registered one edge late, the probe two edges late
module vifd_properties
   import vifd_pkg::*;
(
   input logic ref_clk,
   input logic rst,
   input logic in_valid,
   input logic [0:63] in_word,
   input logic job_mode,
   input vifd_pkg::vifd_opnd_s opnd,
   input logic out_valid,
   input vifd_pkg::vifd_fields_s out_fields,
   input vifd_pkg::vifd_exc_s out_exc,
   input logic [vifd_pkg::LEN_W:0] digit_count,
   input logic probe,
   input logic [vifd_pkg::PAGE_W:0] probe_page
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);

   // decode answer timing and field extraction
   a_answer_next: assert property (in_valid |=> out_valid)
      else $error("no answer one cycle after a presented word");
   a_answer_only: assert property (!in_valid |=> !out_valid)
      else $error("answer without a presented word");
   a_func_bits: assert property (in_valid |=> out_fields.func == $past(in_word[0:7]))
      else $error("function code not taken from bits 0-7");
   a_len_select: assert property (in_valid |=> out_fields.len64 == $past(in_word[0])
      && out_fields.halves == ($past(in_word[0]) ? 2'h2 : 2'h1))
      else $error("word length does not follow the function code");
   a_sub_bits: assert property (in_valid |=> out_fields.sub == $past(in_word[8:15]))
      else $error("subfunction not taken from bits 8-15");
   a_long_regs: assert property (in_valid && in_word[0] |=> out_fields.x == $past(in_word[16:23])
      && out_fields.z == $past(in_word[48:55]) && out_fields.c == $past(in_word[56:63]))
      else $error("long word register designators misplaced");
   a_short_regs: assert property (in_valid && !in_word[0] |=> out_fields.src1 == $past(in_word[8:15])
      && out_fields.src2 == $past(in_word[16:23]) && out_fields.dst == $past(in_word[24:31]))
      else $error("short word register designators misplaced");
   a_digit_pairs: assert property (in_valid |=> digit_count ==
      ($past(opnd.packed_bcd) ? {$past(opnd.bytes), 1'b0} : {1'b0, $past(opnd.bytes)}))
      else $error("digit count does not match byte count");
   a_trap_reg: assert property (out_exc.mon_branch |-> out_exc.mon_reg == 8'h04 && !out_exc.exch_monitor)
      else $error("monitor trap not through register 4");
   a_probe_first: assert property (in_valid && in_word[0:7] == 8'hBC |-> ##2 probe && probe_page == 1)
      else $error("no first page probe for a compress");

   c_long: cover property (in_valid && in_word[0]);
   c_trap: cover property (out_exc.mon_branch);
   c_probe: cover property (probe);
endmodule : vifd_properties

bind vifd_decoder vifd_properties u_props (.ref_clk(ref_clk), .rst(rst), .in_valid(in_valid),
   .in_word(in_word), .job_mode(job_mode), .opnd(opnd), .out_valid(out_valid),
   .out_fields(out_fields), .out_exc(out_exc), .digit_count(digit_count), .probe(probe),
   .probe_page(probe_page));
